// file: hw/ols_consts.svh
// Purpose: named constants for the out-of-band output level selector
// Assumes: 100 MHz mclk
// Notes: symbol codes are 8b values ahead of the 8b/10b encoder
`ifndef OLS_CONSTS_SVH
`define OLS_CONSTS_SVH

`define OLS_CLK_PERIOD_NS 10
`define OLS_HOTPLUG_MS 500
`define OLS_HOTPLUG_CYC ((`OLS_HOTPLUG_MS * 1000000) / `OLS_CLK_PERIOD_NS)
`define OLS_TIMER_W 32

`define OLS_D24_3 8'h78
`define OLS_K28_5 8'hBC
`define OLS_D10_2 8'h4A
`define OLS_D27_3 8'h7B
`define OLS_D30_3 8'h7E
`define OLS_IDLE_CHAR 8'h00

`define OLS_IDX_LAST 2'h3
`define OLS_IDX_ZERO 2'h0

`endif

// file: hw/ols_pkg.sv
// Purpose: types shared by the output level selector files
// Assumes: nothing beyond the constants header
// Notes: link events arrive as one-cycle pulses
package ols_pkg;

	typedef enum logic [2:0] {
		ST_WAIT_INIT,
		ST_COMSAS,
		ST_SAS_LINK,
		ST_SATA_LINK
	} ols_state_e;

	typedef struct packed {
		logic cominit_rx;
		logic comsas_tx_done;
		logic comsas_rx;
		logic comsas_timeout;
	} ols_link_in_s;

	typedef struct packed {
		logic [7:0] data;
		logic k;
		logic active;
	} ols_sym_s;

endpackage : ols_pkg

// file: hw/ols_sym_gen.sv
// Purpose: character source for out-of-band bursts and the equalization pattern
// Assumes: serializer runs the chosen rate from rate_3g
// Notes: test pattern wins over burst; otherwise idle with active low
`timescale 1ns/1ps
`include "ols_consts.svh"

module ols_sym_gen (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// requests
	input wire logic burst_en,
	input wire logic rate_3g,
	input wire logic test_en,
	// character out
	output ols_pkg::ols_sym_s sym
);
	import ols_pkg::*;

	typedef struct packed {
		logic [1:0] idx;
		ols_sym_s sym;
	} ols_gen_s;

	ols_gen_s st_reg;
	ols_gen_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.sym.k = 1'b0;
		st_next.sym.active = 1'b1;
		if (test_en) begin
			st_next.idx = `OLS_IDX_ZERO;
			st_next.sym.data = `OLS_D30_3;
		end else if (burst_en && !rate_3g) begin
			st_next.idx = `OLS_IDX_ZERO;
			st_next.sym.data = `OLS_D24_3;
		end else if (burst_en) begin
			// align primitive, one character per cycle
			st_next.idx = st_reg.idx + 2'h1;
			unique case (st_reg.idx)
				2'h0: begin
					st_next.sym.data = `OLS_K28_5;
					st_next.sym.k = 1'b1;
				end
				2'h1, 2'h2: st_next.sym.data = `OLS_D10_2;
				2'h3: st_next.sym.data = `OLS_D27_3;
			endcase
		end else begin
			// burst always restarts at the comma
			st_next.idx = `OLS_IDX_ZERO;
			st_next.sym.data = `OLS_IDLE_CHAR;
			st_next.sym.active = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sym = st_reg.sym;

endmodule : ols_sym_gen

// file: hw/ols_level_sel.sv
// What this block does
// - with SATA support, first OOB after power-on or hard reset uses SATA levels.
// - no COMINIT within hot-plug timeout of first OOB: switch to SAS, repeat OOB.
// - still no COMINIT after second OOB timeout: start another OOB at SATA levels.
// - keep alternating SATA and SAS levels each timeout until COMINIT arrives.
// - COMSAS both sent and received: select SAS levels before speed negotiation.
// - on SAS levels and no COMSAS received: switch to SATA levels, restart OOB.
// - without SATA support always use SAS levels, never alternate.
// - OOB bursts carry D24.3 at 1.5 Gbps or ALIGN(0) at 3 Gbps.
// - test function can send the two-dword D30.3 equalization pattern.
//
// Purpose: picks SATA or SAS transmit output levels during out-of-band init
// Assumes: link events are one-cycle pulses from the OOB sequencer
// Notes: level_sas high means SAS levels; the analog driver follows it
`timescale 1ns/1ps
`include "ols_consts.svh"

module ols_level_sel #(
	parameter bit SATA_SUPPORT = 1'b1,
	parameter int unsigned HOTPLUG_CYC = `OLS_HOTPLUG_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// restart and link events
	input wire logic hard_reset,
	input ols_pkg::ols_link_in_s link_in,
	// burst content requests
	input wire logic burst_en,
	input wire logic rate_3g,
	input wire logic test_en,
	// level and sequencing outputs
	output logic level_sas,
	output logic oob_start,
	output logic sas_neg_start,
	output ols_pkg::ols_state_e state,
	// character out
	output ols_pkg::ols_sym_s tx_sym
);
	import ols_pkg::*;

	localparam logic [`OLS_TIMER_W-1:0] TIMER_LAST = `OLS_TIMER_W'(HOTPLUG_CYC - 1);

	typedef struct packed {
		ols_state_e state;
		logic level_sas;
		logic [`OLS_TIMER_W-1:0] timer;
		logic comsas_tx_seen;
		logic comsas_rx_seen;
		logic oob_start;
		logic neg_start;
	} ols_ctl_s;

	ols_ctl_s st_reg;
	ols_ctl_s st_next;
	logic expiry;
	logic comsas_both;

	assign expiry = (st_reg.timer == TIMER_LAST);
	assign comsas_both = (st_reg.comsas_tx_seen || link_in.comsas_tx_done)
		&& (st_reg.comsas_rx_seen || link_in.comsas_rx);

	always_comb begin
		st_next = st_reg;
		st_next.oob_start = 1'b0;
		st_next.neg_start = 1'b0;
		st_next.timer = expiry ? st_reg.timer : st_reg.timer + `OLS_TIMER_W'(1);
		if (hard_reset) begin
			// back to the first sequence, same as power-on
			st_next.state = ST_WAIT_INIT;
			st_next.level_sas = !SATA_SUPPORT;
			st_next.timer = '0;
			st_next.oob_start = 1'b1;
			st_next.comsas_tx_seen = 1'b0;
			st_next.comsas_rx_seen = 1'b0;
		end else begin
			unique case (st_reg.state)
				ST_WAIT_INIT: begin
					if (link_in.cominit_rx) begin
						st_next.state = ST_COMSAS;
						st_next.comsas_tx_seen = 1'b0;
						st_next.comsas_rx_seen = 1'b0;
					end else if (expiry) begin
						// only a SATA-capable part alternates
						if (SATA_SUPPORT) begin
							st_next.level_sas = !st_reg.level_sas;
						end
						st_next.timer = '0;
						st_next.oob_start = 1'b1;
					end
				end
				ST_COMSAS: begin
					st_next.comsas_tx_seen = st_reg.comsas_tx_seen || link_in.comsas_tx_done;
					st_next.comsas_rx_seen = st_reg.comsas_rx_seen || link_in.comsas_rx;
					if (comsas_both) begin
						// level step lands in the idle gap before negotiation
						st_next.level_sas = 1'b1;
						st_next.neg_start = 1'b1;
						st_next.state = ST_SAS_LINK;
					end else if (link_in.comsas_timeout) begin
						if (st_reg.level_sas && SATA_SUPPORT) begin
							st_next.level_sas = 1'b0;
							st_next.timer = '0;
							st_next.oob_start = 1'b1;
							st_next.state = ST_WAIT_INIT;
						end else begin
							st_next.state = ST_SATA_LINK;
						end
					end
				end
				ST_SAS_LINK: st_next.state = ST_SAS_LINK;
				ST_SATA_LINK: st_next.state = ST_SATA_LINK;
				default: st_next.state = ST_WAIT_INIT;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg.state <= ST_WAIT_INIT;
			st_reg.level_sas <= !SATA_SUPPORT;
			st_reg.timer <= '0;
			st_reg.comsas_tx_seen <= 1'b0;
			st_reg.comsas_rx_seen <= 1'b0;
			st_reg.oob_start <= 1'b1;
			st_reg.neg_start <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_sas = st_reg.level_sas;
	assign oob_start = st_reg.oob_start;
	assign sas_neg_start = st_reg.neg_start;
	assign state = st_reg.state;

	ols_sym_gen u_sym_gen (
		.mclk(mclk),
		.rst_n(rst_n),
		.burst_en(burst_en),
		.rate_3g(rate_3g),
		.test_en(test_en),
		.sym(tx_sym)
	);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic rst_seen_reg;
	always_ff @(posedge mclk) begin
		rst_seen_reg <= rst_n;
	end

	property p_first_sata;
		!rst_seen_reg |-> (level_sas == !SATA_SUPPORT) && oob_start && state == ST_WAIT_INIT;
	endproperty
	a_first_sata: assert property (p_first_sata) else $error("first OOB not on default level");

	property p_to_sas;
		(state == ST_WAIT_INIT && expiry && !level_sas && !link_in.cominit_rx && !hard_reset)
			|=> level_sas && oob_start;
	endproperty
	a_to_sas: assert property (p_to_sas) else $error("timeout on SATA level did not move to SAS");

	property p_to_sata;
		(state == ST_WAIT_INIT && expiry && level_sas && SATA_SUPPORT && !link_in.cominit_rx && !hard_reset)
			|=> !level_sas && oob_start;
	endproperty
	a_to_sata: assert property (p_to_sata) else $error("timeout on SAS level did not move to SATA");

	property p_hold_level;
		(state == ST_WAIT_INIT && !expiry && !hard_reset) |=> $stable(level_sas) && !oob_start;
	endproperty
	a_hold_level: assert property (p_hold_level) else $error("level changed without a timeout");

	property p_comsas_sas;
		(state == ST_COMSAS && comsas_both && !hard_reset) |=> level_sas && sas_neg_start ##1 !sas_neg_start;
	endproperty
	a_comsas_sas: assert property (p_comsas_sas) else $error("COMSAS exchange did not select SAS");

	property p_no_comsas;
		(state == ST_COMSAS && level_sas && SATA_SUPPORT && !comsas_both && link_in.comsas_timeout && !hard_reset)
			|=> !level_sas && oob_start && state == ST_WAIT_INIT;
	endproperty
	a_no_comsas: assert property (p_no_comsas) else $error("missing COMSAS did not restart on SATA");

	property p_sas_only;
		!SATA_SUPPORT |-> level_sas;
	endproperty
	a_sas_only: assert property (p_sas_only) else $error("SAS-only part left SAS levels");

	property p_d24;
		(burst_en && !rate_3g && !test_en) |=> tx_sym.data == `OLS_D24_3 && !tx_sym.k && tx_sym.active;
	endproperty
	a_d24: assert property (p_d24) else $error("slow burst is not D24.3");

	property p_align;
		(!burst_en ##1 (burst_en && rate_3g && !test_en) [*4]) |=> tx_sym.data == `OLS_D27_3 && !tx_sym.k;
	endproperty
	a_align: assert property (p_align) else $error("fast burst is not an ALIGN primitive");

	property p_test_pat;
		test_en |=> tx_sym.data == `OLS_D30_3 && !tx_sym.k;
	endproperty
	a_test_pat: assert property (p_test_pat) else $error("test pattern is not D30.3");

	property p_timer_restart;
		// a hard reset on the start cycle restarts the count once more
		oob_start |-> st_reg.timer == '0 ##1 (st_reg.timer == `OLS_TIMER_W'(1) || $past(hard_reset));
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("hot-plug timer not restarted");

	c_alternate: cover property (state == ST_WAIT_INIT && !level_sas ##1 level_sas ##[1:1000] !level_sas);
	c_sas_link: cover property (sas_neg_start);
	c_fallback: cover property (state == ST_COMSAS && level_sas ##1 state == ST_WAIT_INIT);
	c_sata_link: cover property (state == ST_SATA_LINK);

endmodule : ols_level_sel

// file: sim/ols_far_phy.sv
// Purpose: attached phy stand-in answering out-of-band sequences
// Assumes: oob_start pulses from the level selector, one cycle long
// Notes: answer low stays silent so hot-plug timeouts expire
`timescale 1ns/1ps

module ols_far_phy (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// controls and observed pulse
	input wire logic oob_start,
	input wire logic answer,
	input wire logic is_sas,
	// link events toward the selector
	output ols_pkg::ols_link_in_s link_in
);
	import ols_pkg::*;
	logic [3:0] cnt_reg;

	// pulses drop back to zero each cycle, never hold a stale event
	always_ff @(posedge mclk) begin
		link_in <= '0;
		if (!rst_n) begin
			cnt_reg <= 4'h0;
		end else if (oob_start && answer) begin
			cnt_reg <= 4'h1;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= (cnt_reg == 4'h7) ? 4'h0 : cnt_reg + 4'h1;
		end
		if (cnt_reg == 4'h3) begin
			link_in.cominit_rx <= 1'b1;
		end
		if (cnt_reg == 4'h5) begin
			link_in.comsas_tx_done <= 1'b1;
		end
		// a sata phy never answers comsas, so the wait runs out
		if (cnt_reg == 4'h7) begin
			link_in.comsas_rx <= is_sas;
			link_in.comsas_timeout <= !is_sas;
		end
	end
endmodule : ols_far_phy

// file: sim/tb_top.sv
// Purpose: self-checking bench for the output level selector
// Assumes: hot-plug timeout shortened to 20 cycles
// Notes: second instance without sata support shares all stimulus
`timescale 1ns/1ps

module tb_top;
	import ols_pkg::*;
	logic mclk, rst_n, hard_reset, burst_en, rate_3g, test_en, answer, is_sas;
	logic level_sas, oob_start, sas_neg_start, lvl_nosata;
	ols_link_in_s link_in;
	ols_state_e state;
	ols_sym_s tx_sym;
	logic [9:0] al [4] = '{{8'hBC, 2'b11}, {8'h4A, 2'b01}, {8'h4A, 2'b01}, {8'h7B, 2'b01}};
	int miscompares = 0;
	int n_compared = 0;

	ols_level_sel #(.SATA_SUPPORT(1'b1), .HOTPLUG_CYC(20)) ols_level_sel_inst (.mclk(mclk), .rst_n(rst_n),
		.hard_reset(hard_reset), .link_in(link_in), .burst_en(burst_en), .rate_3g(rate_3g), .test_en(test_en),
		.level_sas(level_sas), .oob_start(oob_start), .sas_neg_start(sas_neg_start), .state(state), .tx_sym(tx_sym));
	ols_level_sel #(.SATA_SUPPORT(1'b0), .HOTPLUG_CYC(20)) ols_level_sel_inst2 (.mclk(mclk), .rst_n(rst_n),
		.hard_reset(hard_reset), .link_in(link_in), .burst_en(burst_en), .rate_3g(rate_3g), .test_en(test_en),
		.level_sas(lvl_nosata), .oob_start(), .sas_neg_start(), .state(), .tx_sym());
	ols_far_phy ols_far_phy_inst (.mclk(mclk), .rst_n(rst_n), .oob_start(oob_start), .answer(answer),
		.is_sas(is_sas), .link_in(link_in));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task end_sim;
		if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task tick;
		@(posedge mclk);
		#1;
	endtask : tick

	// sel 0 waits on oob_start, 1 on sas_neg_start
	task wait_for(input int sel);
		int i;
		i = 0;
		while (((sel == 0) ? oob_start : sas_neg_start) !== 1'b1) begin
			tick;
			i++;
			if (i > 100) begin
				miscompares++;
				end_sim;
			end
		end
	endtask : wait_for

	task do_hard;
		hard_reset = 1'b1;
		tick;
		hard_reset = 1'b0;
		check(level_sas, 1'b0);
		check(oob_start, 1'b1);
	endtask : do_hard

	task sc_alternate;
		logic lv;
		answer = 1'b0;
		do_hard;
		for (int k = 0; k < 3; k++) begin
			lv = level_sas;
			repeat (19) tick;
			check(oob_start, 1'b0);
			check(level_sas, lv);
			tick;
			check(oob_start, 1'b1);
			check(level_sas, !lv);
		end
	endtask : sc_alternate

	task sc_sas;
		answer = 1'b1;
		is_sas = 1'b1;
		do_hard;
		wait_for(1);
		check(level_sas, 1'b1);
		check(state, ST_SAS_LINK);
		tick;
		check(sas_neg_start, 1'b0);
	endtask : sc_sas

	task sc_sata;
		answer = 1'b0;
		is_sas = 1'b0;
		do_hard;
		tick;
		answer = 1'b1;
		wait_for(0);
		check(level_sas, 1'b1);
		tick;
		wait_for(0);
		check(level_sas, 1'b0);
		check(state, ST_WAIT_INIT);
		repeat (12) tick;
		check(state, ST_SATA_LINK);
		check(level_sas, 1'b0);
	endtask : sc_sata

	task sc_chars;
		burst_en = 1'b1;
		rate_3g = 1'b1;
		for (int i = 0; i < 8; i++) begin
			tick;
			check(tx_sym, al[i % 4]);
		end
		rate_3g = 1'b0;
		tick;
		check(tx_sym, {8'h78, 2'b01});
		test_en = 1'b1;
		tick;
		check(tx_sym, {8'h7E, 2'b01});
		test_en = 1'b0;
		burst_en = 1'b0;
		tick;
		check(tx_sym, 10'h000);
		burst_en = 1'b1;
		rate_3g = 1'b1;
		tick;
		check(tx_sym, al[0]);
		burst_en = 1'b0;
	endtask : sc_chars

	// the sas-only build must never leave sas levels
	initial begin
		forever begin
			tick;
			if (rst_n) check(lvl_nosata, 1'b1);
		end
	end

	initial begin
		rst_n = 1'b0;
		hard_reset = 1'b0;
		burst_en = 1'b0;
		rate_3g = 1'b0;
		test_en = 1'b0;
		answer = 1'b0;
		is_sas = 1'b0;
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		check(state, ST_WAIT_INIT);
		check(level_sas, 1'b0);
		check(oob_start, 1'b1);
		sc_alternate;
		sc_sas;
		sc_sata;
		sc_chars;
		end_sim;
	end
endmodule : tb_top
